/* File: src/cmpc_pwm_control.sv */
`timescale 1ns/1ps
module cmpc_pwm_control #(
	parameter int unsigned CLK_FREQ_HZ = cmpc_pkg::CLK_HZ_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire cmpc_pkg::cmpc_cfg_t cfg,
	input wire cmpc_pkg::cmpc_phase_t phaseCmp,
	input wire logic cmpOpampHigh,
	input wire logic cmpFbHigh,
	output logic pwmOut,
	output logic currentRefPin,
	output logic measWindow,
	output logic currentLimitEvent,
	output logic cmpEnabled
);
	import cmpc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Cycle tables derived from the clock rate
	logic [CNT_W-1:0] periodTab [TAB_N];
	logic [CNT_W-1:0] offTab [TAB_N];
	logic [CNT_W-1:0] blankTab [BLANK_N];

	for (genvar i = 0; i < TAB_N; i++) begin : g_tab
		assign periodTab[i] = CNT_W'(cmpc_period_cycles(i, CLK_FREQ_HZ));
		assign offTab[i] = CNT_W'(cmpc_ns_cycles(longint'(i + 1) * OFF_STEP_NS,
			CLK_FREQ_HZ));
	end
	for (genvar i = 0; i < BLANK_N; i++) begin : g_blank
		assign blankTab[i] = CNT_W'(cmpc_ns_cycles(longint'(i) * BLANK_STEP_NS,
			CLK_FREQ_HZ));
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [CNT_W-1:0] periodCnt_reg;
	logic [CNT_W-1:0] periodCnt_next;
	logic [CNT_W-1:0] blankCnt_reg;
	logic [CNT_W-1:0] blankCnt_next;
	logic [1:0] sampleDiv_reg;
	logic [1:0] sampleDiv_next;
	logic limitHit_reg;
	logic limitHit_next;
	logic pwmOut_reg;
	logic pwmOut_next;
	logic currentRef_reg;
	logic currentRef_next;
	logic measWindow_reg;
	logic measWindow_next;

	////////////////////////////////////////////////////////////////////////
	// Decode
	logic currMode;
	logic noMinOff;
	logic [CNT_W-1:0] periodLen;
	logic [CNT_W-1:0] minOffLen;
	logic periodStart;
	logic window;
	logic fullDuty;
	logic pwmCurr;
	logic onStart;
	logic blanking;
	logic sampleEn;
	logic cmpRaw;
	logic cmpValid;
	logic filterHit;
	logic filterRestart;
	logic limitEvent;

	assign currMode = (cfg.voltCurrSel == CMPC_CURR);
	assign noMinOff = cfg.sensorModeSel || cfg.sampleOnTime
		|| (cfg.zcSampleDelay != DELAY_NONE);
	assign periodLen = periodTab[cfg.windowFreqSel];
	assign minOffLen = noMinOff ? CNT_ZERO : offTab[cfg.minOffSel];
	assign periodStart = (periodCnt_reg == CNT_ZERO);
	assign window = (periodCnt_reg < minOffLen);
	assign fullDuty = (minOffLen > periodLen);
	assign pwmCurr = fullDuty || (!window && !periodStart && !limitHit_reg);
	assign pwmOut_next = currMode ? pwmCurr : phaseCmp.u;
	assign onStart = currMode && pwmOut_next && !pwmOut_reg;
	assign blanking = (blankCnt_reg != CNT_ZERO);

	assign cmpEnabled = cfg.periphClkEn || cfg.directAccess;
	assign cmpRaw = cfg.cmpInputSel ? cmpFbHigh : cmpOpampHigh;
	assign cmpValid = cmpEnabled && cmpRaw && !blanking;
	assign sampleEn = (sampleDiv_reg == DIV_LAST);
	assign filterRestart = onStart || !pwmOut_reg || !currMode;
	assign limitEvent = currMode && pwmOut_reg && filterHit;

	////////////////////////////////////////////////////////////////////////
	// Next-state
	assign periodCnt_next = (periodCnt_reg >= periodLen - CNT_ONE) ? CNT_ZERO
		: periodCnt_reg + CNT_ONE;
	assign blankCnt_next = onStart ? blankTab[cfg.blankLenSel]
		: (blanking ? blankCnt_reg - CNT_ONE : CNT_ZERO);
	assign sampleDiv_next = sampleDiv_reg + 2'h1;
	// A limit in the same cycle as the period start still holds
	assign limitHit_next = limitEvent ? 1'b1 : (periodStart ? 1'b0 : limitHit_reg);
	assign currentRef_next = cfg.phaseURefEn ? phaseCmp.u
		: cfg.phaseVRefEn ? phaseCmp.v
		: cfg.phaseWRefEn ? phaseCmp.w : 1'b0;
	assign measWindow_next = currMode && !cfg.sensorModeSel && window;

	always_ff @(posedge clk) begin
		if (rst) begin
			periodCnt_reg <= CNT_ZERO;
			blankCnt_reg <= CNT_ZERO;
			sampleDiv_reg <= DIV_ZERO;
			limitHit_reg <= 1'b0;
			pwmOut_reg <= 1'b0;
			currentRef_reg <= 1'b0;
			measWindow_reg <= 1'b0;
		end else begin
			periodCnt_reg <= periodCnt_next;
			blankCnt_reg <= blankCnt_next;
			sampleDiv_reg <= sampleDiv_next;
			limitHit_reg <= limitHit_next;
			pwmOut_reg <= pwmOut_next;
			currentRef_reg <= currentRef_next;
			measWindow_reg <= measWindow_next;
		end
	end

	cmpc_sample_filter #(
		.CW(SEL3_W)
	) u_filter (
		.clk(clk),
		.rst(rst),
		.sampleEn(sampleEn),
		.sampleHigh(cmpValid),
		.restart(filterRestart),
		.needSel(cfg.sampleCountSel),
		.hit(filterHit)
	);

	assign pwmOut = pwmOut_reg;
	assign currentRefPin = currentRef_reg;
	assign measWindow = measWindow_reg;
	assign currentLimitEvent = limitEvent;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	volt_mode_a: assert property (!currMode |=> pwmOut == $past(phaseCmp.u))
		else $error("voltage mode output not following phase U");
	curr_ref_a: assert property (cfg.phaseURefEn |=> currentRefPin == $past(phaseCmp.u))
		else $error("current reference not following phase U");
	blank_mask_a: assert property (blanking |-> !cmpValid)
		else $error("comparator seen during blanking");
	blank_load_a: assert property (onStart |=> blankCnt_reg == $past(blankTab[cfg.blankLenSel]))
		else $error("blanking length wrong");
	sample_rate_a: assert property (sampleEn |=> !sampleEn [*3] ##1 sampleEn)
		else $error("sample strobe not every fourth cycle");
	limit_off_a: assert property (limitEvent && currMode |=> fullDuty || !pwmCurr)
		else $error("PWM not turned off by limit");
	window_off_a: assert property (currMode && window && !fullDuty |=> !pwmOut)
		else $error("PWM on inside window");
	cmp_off_a: assert property (!cmpEnabled |-> !cmpValid)
		else $error("comparator active while disabled");
	input_sel_a: assert property (cfg.cmpInputSel && !cmpFbHigh |-> !cmpValid)
		else $error("wrong comparator input");
	full_duty_a: assert property (currMode && fullDuty |=> pwmOut)
		else $error("full duty not forced");
	no_min_off_a: assert property (noMinOff |-> !window)
		else $error("minimum off time in sensor mode");
	meas_win_a: assert property (cfg.sensorModeSel |=> !measWindow)
		else $error("window exposed in sensor mode");

	on_phase_c: cover property (currMode ##1 onStart ##[1:1000] limitEvent);
	full_duty_c: cover property (currMode && fullDuty);
	blank_c: cover property (onStart && cfg.blankLenSel != BLANK_OFF);
endmodule : cmpc_pwm_control

/* File: pkg/cmpc_pkg.sv */
package cmpc_pkg;
	localparam int unsigned CLK_HZ_DEF = 25_000_000;
	localparam longint unsigned NS_PER_S = 1_000_000_000;
	localparam int unsigned BLANK_STEP_NS = 500;
	localparam int unsigned OFF_STEP_NS = 2500;
	localparam int unsigned SAMPLE_DIV = 4;
	localparam int unsigned CNT_W = 17;
	localparam int unsigned SEL3_W = 3;
	localparam int unsigned SEL4_W = 4;
	localparam int unsigned TAB_N = 16;
	localparam int unsigned BLANK_N = 8;
	localparam logic [2:0] BLANK_OFF = 3'h0;
	localparam logic [2:0] SAMPLE_RST = 3'h0;
	localparam logic [3:0] DELAY_NONE = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 17'h0_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 17'h0_0001;
	localparam logic [1:0] DIV_ZERO = 2'h0;
	localparam logic [1:0] DIV_LAST = 2'h3;

	typedef enum logic {
		CMPC_VOLT = 1'b0,
		CMPC_CURR = 1'b1
	} cmpc_mode_t;

	typedef struct packed {
		cmpc_mode_t voltCurrSel;
		logic [2:0] blankLenSel;
		logic [2:0] sampleCountSel;
		logic [3:0] windowFreqSel;
		logic [3:0] minOffSel;
		logic sensorModeSel;
		logic sampleOnTime;
		logic [3:0] zcSampleDelay;
		logic cmpInputSel;
		logic opampOn;
		logic periphClkEn;
		logic directAccess;
		logic phaseURefEn;
		logic phaseVRefEn;
		logic phaseWRefEn;
	} cmpc_cfg_t;

	typedef struct packed {
		logic u;
		logic v;
		logic w;
	} cmpc_phase_t;

	// Window frequency in Hz per code
	function automatic int unsigned cmpc_win_hz(input int unsigned code);
		case (code)
			0: return 50000;
			1: return 40000;
			2: return 33333;
			3: return 25000;
			4: return 20000;
			5: return 18100;
			6: return 15400;
			7: return 12500;
			8: return 10000;
			9: return 6250;
			10: return 3130;
			11: return 1560;
			12: return 1250;
			13: return 961;
			14: return 625;
			default: return 390;
		endcase
	endfunction : cmpc_win_hz

	// Least time, rounded up to whole cycles
	function automatic int unsigned cmpc_ns_cycles(input longint unsigned ns,
		input longint unsigned hz);
		return int'((ns * hz + NS_PER_S - 1) / NS_PER_S);
	endfunction : cmpc_ns_cycles

	// Period, rounded down, never below one cycle
	function automatic int unsigned cmpc_period_cycles(input int unsigned code,
		input int unsigned hz);
		int unsigned p;
		p = hz / cmpc_win_hz(code);
		return (p == 0) ? 1 : p;
	endfunction : cmpc_period_cycles
endpackage : cmpc_pkg

/* File: src/cmpc_sample_filter.sv */
`timescale 1ns/1ps
module cmpc_sample_filter #(
	parameter int unsigned CW = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sampleEn,
	input wire logic sampleHigh,
	input wire logic restart,
	input wire logic [CW-1:0] needSel,
	output logic hit
);
	logic [CW:0] count_reg;
	logic [CW:0] count_next;
	logic hit_reg;
	logic reached;

	assign reached = (count_reg >= {1'b0, needSel});
	always_comb begin
		count_next = count_reg;
		if (restart || (sampleEn && !sampleHigh)) begin
			count_next = '0;
		end else if (sampleEn && !reached) begin
			count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= '0;
			hit_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			hit_reg <= !restart && sampleEn && sampleHigh && reached;
		end
	end
	assign hit = hit_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	filter_restart_a: assert property (restart |=> !hit && count_reg == '0)
		else $error("sample count not cleared on restart");
	filter_low_a: assert property (sampleEn && !sampleHigh && !restart |=> !hit)
		else $error("event after a low sample");
	filter_count_a: assert property (hit |-> $past(count_reg) >= {1'b0, $past(needSel)})
		else $error("event before enough samples");
endmodule : cmpc_sample_filter

/* File: tb/cmpc_current_sense.sv */
`timescale 1ns/1ps
module cmpc_current_sense (
	input wire logic clk,
	input wire logic rst,
	input wire logic pwmOut,
	input wire logic [15:0] limitCyc,
	input wire logic senseSel,
	output logic cmpOpampHigh,
	output logic cmpFbHigh
);
	logic [15:0] cur_reg;
	logic aboveLim;
	// Winding current ramps while on, collapses when off
	always_ff @(posedge clk) begin
		if (rst || !pwmOut) begin
			cur_reg <= 16'h0000;
		end else if (cur_reg != 16'hffff) begin
			cur_reg <= cur_reg + 16'h0001;
		end
	end
	assign aboveLim = (cur_reg >= limitCyc);
	// Unrouted path shows the opposite level
	assign cmpOpampHigh = senseSel ? ~aboveLim : aboveLim;
	assign cmpFbHigh = senseSel ? aboveLim : ~aboveLim;
endmodule : cmpc_current_sense

/* File: tb/cmpc_pwm_control_test.sv */
`timescale 1ns/1ps
module cmpc_pwm_control_test;
	import cmpc_pkg::*;
	localparam int unsigned HZ = 2_500_000;
	localparam int PER [16] = '{50, 62, 75, 100, 125, 138, 162, 200, 250, 400, 798,
		1602, 2000, 2601, 4000, 6410};
	logic clk = 1'b0;
	logic rst = 1'b1;
	cmpc_cfg_t cfg = '0;
	cmpc_phase_t phaseCmp = '0;
	logic cmpOpampHigh, cmpFbHigh, pwmOut, currentRefPin, measWindow;
	logic currentLimitEvent, cmpEnabled;
	logic [15:0] limitCyc = 16'hffff;
	logic senseSel = 1'b0;
	int errTotal = 0;
	int checked = 0;
	int lo, hi, h0, cnt, bl;
	always #20 clk = ~clk;
	cmpc_pwm_control #(.CLK_FREQ_HZ(HZ)) cmpc_pwm_control_inst (.clk(clk), .rst(rst),
		.cfg(cfg), .phaseCmp(phaseCmp), .cmpOpampHigh(cmpOpampHigh), .cmpFbHigh(cmpFbHigh),
		.pwmOut(pwmOut), .currentRefPin(currentRefPin), .measWindow(measWindow),
		.currentLimitEvent(currentLimitEvent), .cmpEnabled(cmpEnabled));
	cmpc_current_sense cmpc_current_sense_inst (.clk(clk), .rst(rst), .pwmOut(pwmOut),
		.limitCyc(limitCyc), .senseSel(senseSel), .cmpOpampHigh(cmpOpampHigh),
		.cmpFbHigh(cmpFbHigh));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errTotal++;
			$display("CHECK FAILED at %0t: saw %0d want %0d", $time, seen, exp);
		end
	endtask : chk
	task automatic completeRun();
		if (errTotal == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : completeRun
	// Low and high length of one whole period after the next fall
	task automatic meas(output int l, output int h);
		int g;
		g = 0;
		l = 0;
		h = 0;
		while (pwmOut !== 1'b1 && g < 30000) begin
			@(negedge clk);
			g++;
		end
		while (pwmOut !== 1'b0 && g < 30000) begin
			@(negedge clk);
			g++;
		end
		while (pwmOut === 1'b0 && g < 30000) begin
			@(negedge clk);
			l++;
			g++;
		end
		while (pwmOut === 1'b1 && g < 30000) begin
			@(negedge clk);
			h++;
			g++;
		end
	endtask : meas
	// High cycles of one output: 0 PWM, 1 window, 2 limit event
	task automatic count(input int n, input int sel);
		cnt = 0;
		repeat (n) begin
			@(negedge clk);
			cnt += (sel == 0) ? pwmOut : ((sel == 1) ? measWindow : currentLimitEvent);
		end
	endtask : count
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(100000 * 40);
		errTotal++;
		completeRun();
	end
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk(pwmOut, 0);
		chk(cmpEnabled, 0);
		cfg.voltCurrSel = CMPC_CURR;
		for (int c = 0; c < 16; c++) begin
			cfg.windowFreqSel = 4'(c);
			meas(lo, hi);
			chk(lo, 7);
			chk(lo + hi, PER[c]);
		end
		cfg.windowFreqSel = 4'h3;
		for (int c = 0; c < 15; c++) begin
			cfg.minOffSel = 4'(c);
			meas(lo, hi);
			chk(lo, ((c + 1) * 25 + 3) / 4);
			chk(lo + hi, 100);
		end
		cfg.windowFreqSel = 4'h0;
		repeat (100) @(negedge clk);
		count(200, 0);
		chk(cnt, 200);
		cfg.windowFreqSel = 4'h3;
		cfg.minOffSel = 4'h0;
		count(200, 1);
		chk(cnt, 14);
		for (int m = 0; m < 3; m++) begin
			cfg.sensorModeSel = (m == 0);
			cfg.sampleOnTime = (m == 1);
			cfg.zcSampleDelay = (m == 2) ? 4'h1 : 4'h0;
			meas(lo, hi);
			chk(lo, 1);
		end
		cfg.zcSampleDelay = 4'h0;
		cfg.periphClkEn = 1'b1;
		cfg.opampOn = 1'b1;
		limitCyc = 16'h0000;
		for (int k = 0; k < 8; k++) begin
			cfg.sampleCountSel = 3'(k);
			meas(lo, hi);
			chk(lo + hi, 100);
			if (k == 0) h0 = hi;
			else chk(hi - h0, 4 * k);
		end
		chk(h0 >= 1 && h0 <= 6, 1);
		count(100, 2);
		chk(cnt, 1);
		cfg.sampleCountSel = 3'h0;
		for (int b = 1; b < 8; b++) begin
			cfg.blankLenSel = 3'(b);
			bl = (b * 5 + 3) / 4;
			meas(lo, hi);
			chk(hi + 4 >= h0 + bl && hi <= h0 + bl + 4, 1);
		end
		cfg.blankLenSel = 3'h0;
		cfg.cmpInputSel = 1'b1;
		meas(lo, hi);
		chk(hi, 93);
		senseSel = 1'b1;
		meas(lo, hi);
		chk(hi, h0);
		cfg.periphClkEn = 1'b0;
		meas(lo, hi);
		chk(hi, 93);
		chk(cmpEnabled, 0);
		cfg.directAccess = 1'b1;
		meas(lo, hi);
		chk(hi, h0);
		chk(cmpEnabled, 1);
		for (int p = 0; p < 3; p++) begin
			{cfg.phaseURefEn, cfg.phaseVRefEn, cfg.phaseWRefEn} = 3'h4 >> p;
			phaseCmp = cmpc_phase_t'(3'h4 >> p);
			repeat (2) @(negedge clk);
			chk(currentRefPin, 1);
			phaseCmp = cmpc_phase_t'(~(3'h4 >> p));
			repeat (2) @(negedge clk);
			chk(currentRefPin, 0);
		end
		cfg.voltCurrSel = CMPC_VOLT;
		for (int i = 0; i < 6; i++) begin
			phaseCmp.u = i[0];
			@(negedge clk);
			chk(pwmOut, i[0]);
		end
		completeRun();
	end
endmodule : cmpc_pwm_control_test
